// [metering_cfg_map.svh]
// Contract
// - Angle codes 01 volt, 10 current, 11 off
// - Code 00 measures voltage to current angles
// - Bit 11 substitutes nominal voltage, phase A
// - Bit 12 substitutes nominal voltage, phase B
// - Bit 13 substitutes nominal voltage, phase C
// - Bit 15 resets zero, no function
// - Phase current gain codes, reserved act 000
// - Neutral current gain codes, reserved act 000
// - Phase voltage gain codes, reserved act 000
// - Gain bits 15 to 9 reset zero, inert
`ifndef METERING_CFG_MAP_SVH
`define METERING_CFG_MAP_SVH
// ----------------------------------------------------------------
// Register indices; byte address is four times the index
// ----------------------------------------------------------------
`define CM_INDEX 16'he60e
`define GS_INDEX 16'he60f
`define CM_ADDR ({`CM_INDEX, 2'b00})
`define GS_ADDR ({`GS_INDEX, 2'b00})
// ----------------------------------------------------------------
// Field positions in the computation mode register
// ----------------------------------------------------------------
`define CM_ANGLE_LSB 9
`define CM_ANGLE_MSB 10
`define CM_NOM_A_BIT 11
`define CM_NOM_B_BIT 12
`define CM_NOM_C_BIT 13
`define CM_FREQ_BIT 14
`define CM_SPARE_BIT 15
// ----------------------------------------------------------------
// Field positions in the gain register
// ----------------------------------------------------------------
`define GS_PHI_LSB 0
`define GS_PHI_MSB 2
`define GS_NEU_LSB 3
`define GS_NEU_MSB 5
`define GS_VOLT_LSB 6
`define GS_VOLT_MSB 8
// ----------------------------------------------------------------
// Reset values and gain decode limits
// ----------------------------------------------------------------
`define CM_RESET 16'h01ff
`define GS_RESET 16'h0000
`define GAIN_CODE_MAX 3'h4
`define GAIN_CODE_UNITY 3'h0
`define GAIN_FACTOR_ONE 5'h01
`endif

// [metering_cfg_pkg.sv]
package metering_cfg_pkg;
  // Angle measurement selection
  typedef enum logic [1:0] {
    ANGLE_VOLT_CURR = 2'b00,
    ANGLE_VOLT_VOLT = 2'b01,
    ANGLE_CURR_CURR = 2'b10,
    ANGLE_NONE = 2'b11
  } angle_mode_t;
  // Gain selection code as stored
  typedef logic [2:0] gain_code_t;
  // Gain factor 1..16
  typedef logic [4:0] gain_factor_t;
endpackage : metering_cfg_pkg

// [metering_compute_gain_config.sv]
`timescale 1ns/100ps
`default_nettype none
`include "metering_cfg_map.svh"
module metering_compute_gain_config #(
  parameter int ADDR_W = 18,
  parameter int RMS_W = 24
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Measured rms voltages and nominal value from the datapath
  input wire logic [RMS_W-1:0] rms_volt_a_in,
  input wire logic [RMS_W-1:0] rms_volt_b_in,
  input wire logic [RMS_W-1:0] rms_volt_c_in,
  input wire logic [RMS_W-1:0] nominal_voltage_value_in,
  // Voltages chosen for apparent power
  output logic [RMS_W-1:0] apparent_volt_a_out,
  output logic [RMS_W-1:0] apparent_volt_b_out,
  output logic [RMS_W-1:0] apparent_volt_c_out,
  // Substitution flags per phase
  output logic nominal_volt_sub_phase_a_out,
  output logic nominal_volt_sub_phase_b_out,
  output logic nominal_volt_sub_phase_c_out,
  // Angle measurement controls
  output metering_cfg_pkg::angle_mode_t angle_measure_select_out,
  output logic angle_volt_curr_en_out,
  output logic angle_volt_volt_en_out,
  output logic angle_curr_curr_en_out,
  // Line frequency
  output logic line_frequency_select_out,
  // Effective gain codes and factors
  output metering_cfg_pkg::gain_code_t phase_current_gain_out,
  output metering_cfg_pkg::gain_code_t neutral_current_gain_out,
  output metering_cfg_pkg::gain_code_t phase_voltage_gain_out,
  output metering_cfg_pkg::gain_factor_t phase_current_factor_out,
  output metering_cfg_pkg::gain_factor_t neutral_current_factor_out,
  output metering_cfg_pkg::gain_factor_t phase_voltage_factor_out
);
  import metering_cfg_pkg::*;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // Reserved gain codes fold onto unity so the front end never sees
  // an undefined setting
  function automatic gain_code_t fold_gain(input gain_code_t code);
    begin
      if (code > `GAIN_CODE_MAX)
      begin
        fold_gain = `GAIN_CODE_UNITY;
      end
      else
      begin
        fold_gain = code;
      end
    end
  endfunction : fold_gain

  // Factor is two to the power of the folded code
  function automatic gain_factor_t gain_factor(input gain_code_t code);
    begin
      gain_factor = gain_factor_t'(`GAIN_FACTOR_ONE << fold_gain(code));
    end
  endfunction : gain_factor

  // Byte lane merge over the low half word; upper lanes hold nothing
  function automatic logic [15:0] merge_lanes(
    input logic [15:0] old_val,
    input logic [15:0] new_val,
    input logic [1:0] strb
  );
    logic [15:0] mask;
    begin
      mask = {{8{strb[1]}}, {8{strb[0]}}};
      merge_lanes = (old_val & ~mask) | (new_val & mask);
    end
  endfunction : merge_lanes

  // Nominal voltage replaces the measured one when asked
  function automatic logic [RMS_W-1:0] pick_rms(
    input logic sub,
    input logic [RMS_W-1:0] measured,
    input logic [RMS_W-1:0] nominal
  );
    begin
      pick_rms = sub ? nominal : measured;
    end
  endfunction : pick_rms

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [15:0] computation_mode_reg; // Mode register contents
  logic [15:0] computation_mode_next; // Value after a write
  logic [15:0] input_gain_select_reg; // Gain register contents
  logic [15:0] input_gain_select_next; // Value after a write
  logic [31:0] prdata_reg; // Read data captured at setup
  logic [31:0] prdata_next; // Read data to capture
  logic pslverr_reg; // Unmapped flag captured at setup
  logic pslverr_next; // Unmapped flag to capture

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire logic hit_mode; // Address selects the mode register
  wire logic hit_gain; // Address selects the gain register
  wire logic hit_any; // Address maps to a register
  wire logic setup_phase; // First cycle of a transfer
  wire logic access_phase; // Completing cycle of a transfer
  wire logic write_mode; // Write lands in the mode register
  wire logic write_gain; // Write lands in the gain register

  assign hit_mode = (paddr_in == ADDR_W'(`CM_ADDR));
  assign hit_gain = (paddr_in == ADDR_W'(`GS_ADDR));
  assign hit_any = hit_mode | hit_gain;
  assign setup_phase = psel_in & ~penable_in;
  assign access_phase = psel_in & penable_in;
  // Writes to unmapped addresses are dropped and flagged as errors
  assign write_mode = access_phase & pwrite_in & hit_mode;
  assign write_gain = access_phase & pwrite_in & hit_gain;

  // Each field keeps its value until the host writes it again
  assign computation_mode_next = write_mode ?
    merge_lanes(computation_mode_reg, pwdata_in[15:0], pstrb_in[1:0]) :
    computation_mode_reg;
  // Spare bits 15..9 are stored but steer nothing
  assign input_gain_select_next = write_gain ?
    merge_lanes(input_gain_select_reg, pwdata_in[15:0], pstrb_in[1:0]) :
    input_gain_select_reg;

  // Read data is chosen during setup so it comes from a flip-flop
  // in the access cycle; that costs nothing since pready is high
  assign prdata_next = hit_mode ? {16'h0000, computation_mode_reg} :
    hit_gain ? {16'h0000, input_gain_select_reg} :
    32'h0000_0000;
  assign pslverr_next = ~hit_any;

  // ----------------------------------------------------------------
  // Register update
  // ----------------------------------------------------------------

  // Bit 15 and gain bits 15..9 come out of reset as zero
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      computation_mode_reg <= `CM_RESET;
      input_gain_select_reg <= `GS_RESET;
    end
    else
    begin
      computation_mode_reg <= computation_mode_next;
      input_gain_select_reg <= input_gain_select_next;
    end
  end

  // Read data and error flag are taken at the end of setup
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end
    else if (setup_phase)
    begin
      prdata_reg <= prdata_next;
      pslverr_reg <= pslverr_next;
    end
    else
    begin
      prdata_reg <= prdata_reg;
      pslverr_reg <= pslverr_reg;
    end
  end

  // Zero wait state slave: each access completes in its first cycle
  assign pready_out = 1'b1;
  assign prdata_out = prdata_reg;
  // Error shows only while the access phase is on the bus
  assign pslverr_out = access_phase & pslverr_reg;

  // ----------------------------------------------------------------
  // Field extraction and decode
  // ----------------------------------------------------------------
  wire angle_mode_t angle_sel; // Stored angle field
  wire logic sub_a; // Phase A uses nominal voltage
  wire logic sub_b; // Phase B uses nominal voltage
  wire logic sub_c; // Phase C uses nominal voltage
  wire logic freq_sel; // Line frequency choice
  wire gain_code_t phi_raw; // Stored phase current code
  wire gain_code_t neu_raw; // Stored neutral current code
  wire gain_code_t volt_raw; // Stored phase voltage code

  assign angle_sel = angle_mode_t'(
    computation_mode_reg[`CM_ANGLE_MSB:`CM_ANGLE_LSB]);
  assign sub_a = computation_mode_reg[`CM_NOM_A_BIT];
  assign sub_b = computation_mode_reg[`CM_NOM_B_BIT];
  assign sub_c = computation_mode_reg[`CM_NOM_C_BIT];
  // Only the host knows the mains; the bit is passed on as written
  assign freq_sel = computation_mode_reg[`CM_FREQ_BIT];
  assign phi_raw = input_gain_select_reg[`GS_PHI_MSB:`GS_PHI_LSB];
  assign neu_raw = input_gain_select_reg[`GS_NEU_MSB:`GS_NEU_LSB];
  assign volt_raw = input_gain_select_reg[`GS_VOLT_MSB:`GS_VOLT_LSB];

  // Angle enables from the select code
  logic en_vi; // Voltage to current angles
  logic en_vv; // Voltage to voltage angles
  logic en_ii; // Current to current angles

  // All four codes are legal, so no default arm is needed
  always_comb
  begin
    en_vi = 1'b0;
    en_vv = 1'b0;
    en_ii = 1'b0;
    unique case (angle_sel)
      ANGLE_VOLT_CURR: en_vi = 1'b1;
      ANGLE_VOLT_VOLT: en_vv = 1'b1;
      ANGLE_CURR_CURR: en_ii = 1'b1;
      ANGLE_NONE: en_vi = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Registered control outputs
  // ----------------------------------------------------------------

  // Outputs lag the register by one cycle; the datapath updates
  // slowly, so the extra cycle is harmless and keeps outputs glitch
  // free
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      angle_measure_select_out <= ANGLE_VOLT_CURR;
      angle_volt_curr_en_out <= 1'b1;
      angle_volt_volt_en_out <= 1'b0;
      angle_curr_curr_en_out <= 1'b0;
      line_frequency_select_out <= 1'b0;
    end
    else
    begin
      angle_measure_select_out <= angle_sel;
      angle_volt_curr_en_out <= en_vi;
      angle_volt_volt_en_out <= en_vv;
      angle_curr_curr_en_out <= en_ii;
      line_frequency_select_out <= freq_sel;
    end
  end

  // Effective gains: reserved codes never leave this block
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      phase_current_gain_out <= `GAIN_CODE_UNITY;
      neutral_current_gain_out <= `GAIN_CODE_UNITY;
      phase_voltage_gain_out <= `GAIN_CODE_UNITY;
      phase_current_factor_out <= `GAIN_FACTOR_ONE;
      neutral_current_factor_out <= `GAIN_FACTOR_ONE;
      phase_voltage_factor_out <= `GAIN_FACTOR_ONE;
    end
    else
    begin
      phase_current_gain_out <= fold_gain(phi_raw);
      neutral_current_gain_out <= fold_gain(neu_raw);
      phase_voltage_gain_out <= fold_gain(volt_raw);
      phase_current_factor_out <= gain_factor(phi_raw);
      neutral_current_factor_out <= gain_factor(neu_raw);
      phase_voltage_factor_out <= gain_factor(volt_raw);
    end
  end

  // ----------------------------------------------------------------
  // Apparent power voltage selection
  // ----------------------------------------------------------------

  // The measured input is ignored entirely while substitution is on,
  // so a missing phase voltage cannot disturb apparent power
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      apparent_volt_a_out <= '0;
      apparent_volt_b_out <= '0;
      apparent_volt_c_out <= '0;
      nominal_volt_sub_phase_a_out <= 1'b0;
      nominal_volt_sub_phase_b_out <= 1'b0;
      nominal_volt_sub_phase_c_out <= 1'b0;
    end
    else
    begin
      apparent_volt_a_out <= pick_rms(sub_a, rms_volt_a_in,
        nominal_voltage_value_in);
      apparent_volt_b_out <= pick_rms(sub_b, rms_volt_b_in,
        nominal_voltage_value_in);
      apparent_volt_c_out <= pick_rms(sub_c, rms_volt_c_in,
        nominal_voltage_value_in);
      nominal_volt_sub_phase_a_out <= sub_a;
      nominal_volt_sub_phase_b_out <= sub_b;
      nominal_volt_sub_phase_c_out <= sub_c;
    end
  end

endmodule : metering_compute_gain_config
`default_nettype wire

// [metering_cfg_asserts.sv]
`timescale 1ns/100ps
`default_nettype none
module metering_cfg_asserts #(
  parameter int RMS_W = 24
) (
  // Clock, reset and bus strobes
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  // Datapath voltages
  input wire logic [RMS_W-1:0] rms_volt_a_in,
  input wire logic [RMS_W-1:0] rms_volt_b_in,
  input wire logic [RMS_W-1:0] rms_volt_c_in,
  input wire logic [RMS_W-1:0] nominal_voltage_value_in,
  input wire logic [RMS_W-1:0] apparent_volt_a_out,
  input wire logic [RMS_W-1:0] apparent_volt_b_out,
  input wire logic [RMS_W-1:0] apparent_volt_c_out,
  input wire logic nominal_volt_sub_phase_a_out,
  input wire logic nominal_volt_sub_phase_b_out,
  input wire logic nominal_volt_sub_phase_c_out,
  // Configuration outputs
  input wire metering_cfg_pkg::angle_mode_t angle_measure_select_out,
  input wire logic angle_volt_curr_en_out,
  input wire logic angle_volt_volt_en_out,
  input wire logic angle_curr_curr_en_out,
  input wire logic line_frequency_select_out,
  input wire metering_cfg_pkg::gain_code_t phase_current_gain_out,
  input wire metering_cfg_pkg::gain_code_t neutral_current_gain_out,
  input wire metering_cfg_pkg::gain_code_t phase_voltage_gain_out,
  input wire metering_cfg_pkg::gain_factor_t phase_current_factor_out,
  input wire metering_cfg_pkg::gain_factor_t neutral_current_factor_out,
  input wire metering_cfg_pkg::gain_factor_t phase_voltage_factor_out
);
  import metering_cfg_pkg::*;
  // ----
  // One clock domain, so one default clocking
  // ----
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  // Vacuous at the first edge after reset, $past still sees reset there
  // Flag and voltage are launched at the same edge, so the flag is read
  // now while the voltage inputs are read one cycle back
  sub_phase_a_a: assert property (!$past(sys_rst_in) |->
    apparent_volt_a_out == (nominal_volt_sub_phase_a_out ?
    $past(nominal_voltage_value_in) : $past(rms_volt_a_in)))
    else $error("phase a voltage choice wrong");
  sub_phase_b_a: assert property (!$past(sys_rst_in) |->
    apparent_volt_b_out == (nominal_volt_sub_phase_b_out ?
    $past(nominal_voltage_value_in) : $past(rms_volt_b_in)))
    else $error("phase b voltage choice wrong");
  sub_phase_c_a: assert property (!$past(sys_rst_in) |->
    apparent_volt_c_out == (nominal_volt_sub_phase_c_out ?
    $past(nominal_voltage_value_in) : $past(rms_volt_c_in)))
    else $error("phase c voltage choice wrong");
  // Exactly one angle enable, none for the off code
  angle_vc_a: assert property (angle_volt_curr_en_out ==
    (angle_measure_select_out == ANGLE_VOLT_CURR))
    else $error("volt to current enable wrong");
  angle_other_a: assert property ({angle_volt_volt_en_out,
    angle_curr_curr_en_out} == {angle_measure_select_out == ANGLE_VOLT_VOLT,
    angle_measure_select_out == ANGLE_CURR_CURR})
    else $error("angle enables wrong");
  // Folded codes never exceed four and factor is two to the code
  phase_gain_a: assert property (phase_current_gain_out <= 3'h4 &&
    phase_current_factor_out == 5'h01 << phase_current_gain_out)
    else $error("phase current gain wrong");
  neutral_gain_a: assert property (neutral_current_gain_out <= 3'h4 &&
    neutral_current_factor_out == 5'h01 << neutral_current_gain_out)
    else $error("neutral current gain wrong");
  volt_gain_a: assert property (phase_voltage_gain_out <= 3'h4 &&
    phase_voltage_factor_out == 5'h01 << phase_voltage_gain_out)
    else $error("phase voltage gain wrong");
  // Settings move only one clock after a write edge
  hold_cfg_a: assert property ($changed({angle_measure_select_out,
    line_frequency_select_out, phase_current_gain_out,
    phase_voltage_gain_out}) |-> $past(psel_in, 2) && $past(penable_in, 2) &&
    $past(pwrite_in, 2))
    else $error("setting moved without a write");
endmodule : metering_cfg_asserts
`default_nettype wire

// [metering_compute_gain_config_test.sv]
`timescale 1ns/100ps
`default_nettype none
`include "metering_cfg_map.svh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin num_errors++; \
  $display("CHECK FAILED at %0t: got %h want %h", $time, a, b); end end
module metering_compute_gain_config_test;
  import metering_cfg_pkg::*;
  // ----
  // Bench signals
  // ----
  logic clk_in, sys_rst_in, psel_in, penable_in, pwrite_in;
  logic [17:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out, rd;
  logic [3:0] pstrb_in;
  logic pready_out, pslverr_out, err;
  logic [23:0] rms_in [3];
  logic [23:0] nom_in;
  logic [23:0] app_out [3];
  logic [2:0] sub_out, en_out;
  angle_mode_t sel_out;
  logic freq_out;
  gain_code_t gc [3];
  gain_factor_t gf [3];
  int num_errors, checks, cycles;
  metering_compute_gain_config uut (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .pstrb_in(pstrb_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out),
    .rms_volt_a_in(rms_in[0]), .rms_volt_b_in(rms_in[1]),
    .rms_volt_c_in(rms_in[2]), .nominal_voltage_value_in(nom_in),
    .apparent_volt_a_out(app_out[0]), .apparent_volt_b_out(app_out[1]),
    .apparent_volt_c_out(app_out[2]),
    .nominal_volt_sub_phase_a_out(sub_out[0]),
    .nominal_volt_sub_phase_b_out(sub_out[1]),
    .nominal_volt_sub_phase_c_out(sub_out[2]),
    .angle_measure_select_out(sel_out),
    .angle_volt_curr_en_out(en_out[2]), .angle_volt_volt_en_out(en_out[1]),
    .angle_curr_curr_en_out(en_out[0]), .line_frequency_select_out(freq_out),
    .phase_current_gain_out(gc[0]), .neutral_current_gain_out(gc[1]),
    .phase_voltage_gain_out(gc[2]), .phase_current_factor_out(gf[0]),
    .neutral_current_factor_out(gf[1]), .phase_voltage_factor_out(gf[2])
  );
  // Clock at 25 MHz
  initial
  begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  // ----
  // Closing report and hang guard
  // ----
  task automatic tally_and_finish();
    if (num_errors == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : tally_and_finish
  // Whole run needs under 150 cycles
  always @(posedge clk_in)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      num_errors++;
      tally_and_finish();
    end
  end
  // One APB transfer; returns at the edge that samples pready
  task automatic apb(input logic w, input logic [17:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    @(posedge clk_in);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    pstrb_in <= s;
    @(posedge clk_in);
    penable_in <= 1'b1;
    @(posedge clk_in);
    while (pready_out !== 1'b1)
      @(posedge clk_in);
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask : apb
  task automatic wr(input logic [17:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hf);
  endtask : wr
  task automatic rd_chk(input logic [17:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, 4'h0);
    `CHK({err, rd}, {1'b0, e})
  endtask : rd_chk
  // Let registered outputs land before looking
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : wait_clk
  // ----
  // Main sequence
  // ----
  initial
  begin
    {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in, pstrb_in} = '0;
    rms_in[0] = 24'h111111;
    rms_in[1] = 24'h222222;
    rms_in[2] = 24'h333333;
    nom_in = 24'h0abcde;
    sys_rst_in = 1'b1;
    repeat (3) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    rd_chk(`CM_ADDR, 32'h000001ff);
    rd_chk(`GS_ADDR, 32'h0);
    `CHK(gf[2], 5'h01)
    // Every angle code, one-hot enables, none for the off code
    for (int k = 0; k < 4; k++)
    begin
      wr(`CM_ADDR, 32'h01ff | (k << 9));
      wait_clk(1);
      `CHK(en_out, (k == 3) ? 3'b000 : 3'b100 >> k)
      `CHK(sel_out, angle_mode_t'(k))
    end
    // Every gain code in all three fields; reserved ones fold to unity
    for (int c = 0; c < 8; c++)
    begin
      wr(`GS_ADDR, c * 73);
      wait_clk(1);
      for (int g = 0; g < 3; g++)
      begin
        `CHK(gf[g], (c > 4) ? 5'h01 : 5'h01 << c)
        `CHK(gc[g], gain_code_t'((c > 4) ? 0 : c))
      end
      rd_chk(`GS_ADDR, c * 73);
    end
    // Upper gain bits steer nothing
    wr(`GS_ADDR, 32'hfe49);
    wait_clk(1);
    for (int g = 0; g < 3; g++)
      `CHK(gf[g], 5'h02)
    // Substitution per phase, then bit 15 alone; inputs keep moving
    for (int p = 0; p < 4; p++)
    begin
      wr(`CM_ADDR, 32'h01ff | ((p < 3) ? 32'h800 << p : 32'h8000));
      @(posedge clk_in);
      for (int q = 0; q < 3; q++)
        rms_in[q] <= ~rms_in[q];
      wait_clk(2);
      for (int q = 0; q < 3; q++)
        `CHK(app_out[q], (p == q) ? nom_in : rms_in[q])
      `CHK(en_out, 3'b100)
      `CHK(sub_out, (p < 3) ? 3'b001 << p : 3'b000)
    end
    // Line frequency select passes out
    wr(`CM_ADDR, 32'h41ff);
    wait_clk(1);
    `CHK(freq_out, 1'b1)
    // Low lane only: upper byte keeps its value
    apb(1'b1, `CM_ADDR, 32'h0, 4'b0001);
    rd_chk(`CM_ADDR, 32'h4100);
    // Unmapped place: refused, nothing stored
    apb(1'b1, 18'h00010, 32'hffff, 4'hf);
    `CHK(err, 1'b1)
    apb(1'b0, 18'h00010, 32'h0, 4'h0);
    `CHK({err, rd}, {1'b1, 32'h0})
    rd_chk(`CM_ADDR, 32'h4100);
    // Second reset in mid-run
    @(posedge clk_in);
    sys_rst_in <= 1'b1;
    @(posedge clk_in);
    sys_rst_in <= 1'b0;
    rd_chk(`CM_ADDR, 32'h01ff);
    rd_chk(`GS_ADDR, 32'h0);
    `CHK({freq_out, gf[0]}, {1'b0, 5'h01})
    tally_and_finish();
  end
endmodule : metering_compute_gain_config_test
bind metering_compute_gain_config metering_cfg_asserts #(.RMS_W(RMS_W))
  chk (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in),
    .rms_volt_a_in(rms_volt_a_in), .rms_volt_b_in(rms_volt_b_in),
    .rms_volt_c_in(rms_volt_c_in),
    .nominal_voltage_value_in(nominal_voltage_value_in),
    .apparent_volt_a_out(apparent_volt_a_out),
    .apparent_volt_b_out(apparent_volt_b_out),
    .apparent_volt_c_out(apparent_volt_c_out),
    .nominal_volt_sub_phase_a_out(nominal_volt_sub_phase_a_out),
    .nominal_volt_sub_phase_b_out(nominal_volt_sub_phase_b_out),
    .nominal_volt_sub_phase_c_out(nominal_volt_sub_phase_c_out),
    .angle_measure_select_out(angle_measure_select_out),
    .angle_volt_curr_en_out(angle_volt_curr_en_out),
    .angle_volt_volt_en_out(angle_volt_volt_en_out),
    .angle_curr_curr_en_out(angle_curr_curr_en_out),
    .line_frequency_select_out(line_frequency_select_out),
    .phase_current_gain_out(phase_current_gain_out),
    .neutral_current_gain_out(neutral_current_gain_out),
    .phase_voltage_gain_out(phase_voltage_gain_out),
    .phase_current_factor_out(phase_current_factor_out),
    .neutral_current_factor_out(neutral_current_factor_out),
    .phase_voltage_factor_out(phase_voltage_factor_out)
  );
`default_nettype wire
